// ### design/err_therm_pkg.sv
// Shared constants for the error and thermal protection block
package err_therm_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int          CLK_PERIOD_NS     = 40;
  // Machine-check pulse length, in base clock cycles
  localparam int          MCHK_PULSE_CYCLES = 16;
  localparam logic [4:0]  MCHK_CNT_LOAD     = 5'(MCHK_PULSE_CYCLES);
  // ----------------------------------------
  // Thermal limits
  // ----------------------------------------
  localparam int          TEMP_W            = 8;
  // Trip point in degrees C, sensor codes are whole degrees
  localparam logic [7:0]  TRIP_TEMP_C       = 8'h82;
  // ----------------------------------------
  // Reset values and the open-drain drive level
  // ----------------------------------------
  localparam logic        RST_PIN_HIGH      = 1'b1;
  localparam logic        RST_PIN_LOW       = 1'b0;
  localparam logic [2:0]  RST_SYNC3         = 3'h7;
endpackage

// ### design/pin_sync3.sv
// Three-stage synchroniser with agreement filter for an asynchronous pin
`timescale 1ns/1ps
module pin_sync3
(
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_reset_n,
  // Pin in, filtered level out
  input  wire logic i_pin,
  output logic      o_level
);
  typedef struct packed
  {
    logic [2:0] stage;
    logic       level;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Stage 0 is read only by stage 1, so metastability never reaches the filter
  always_comb
  begin
    next_st = st;
    next_st.stage = {st.stage[1:0], i_pin};
    if (st.stage[2] == st.stage[1])
    begin
      next_st.level = st.stage[2];
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st <= {err_therm_pkg::RST_SYNC3, err_therm_pkg::RST_PIN_HIGH};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_level = st.level;
endmodule // pin_sync3

// ### design/err_therm_protect.sv
// Error and thermal protection signalling of the device
// Contract
// - Assert catastrophic error on any unrecoverable machine check or internal fault.
// - Machine-check class error holds catastrophic error for exactly 16 base clocks.
// - Internal-fault class holds catastrophic error until warm or cold reset.
// - Drive over-temperature low at max safe temperature; engage control if enabled.
// - Over-temperature is open-drain, also sampled; external pull-down engages control.
// - Above about 130 C halt execution and assert thermal shutdown output.
// - Regulator fault raises regulator-fault output with thermal shutdown and shutdown.
`timescale 1ns/1ps
module err_therm_protect
(
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_reset_n,
  input  wire logic       i_warm_reset,
  // Supply good pins, asynchronous
  input  wire logic       i_core_supply_good,
  input  wire logic       i_sustain_supply_good,
  // Internal error events, one-cycle pulses
  input  wire logic       i_machine_check_fault,
  input  wire logic       i_internal_fault,
  input  wire logic       i_regulator_fault_event,
  // Thermal sensor
  input  wire logic       i_at_max_temp,
  input  wire logic [7:0] i_junction_temp,
  input  wire logic       i_tcc_enable,
  // Over-temperature open-drain pin
  input  wire logic       i_over_temperature_n,
  output logic            o_over_temperature_n,
  output logic            o_over_temperature_oe,
  // Outputs
  output logic            o_catastrophic_error_n,
  output logic            o_thermal_shutdown_n,
  output logic            o_thermal_shutdown_oe,
  output logic            o_regulator_fault,
  output logic            o_thermal_control_circuit,
  output logic            o_halt_execution
);
  typedef enum logic [2:0]
  {
    CE_IDLE  = 3'b001,
    CE_PULSE = 3'b010,
    CE_HOLD  = 3'b100
  } cat_state_t;

  typedef struct packed
  {
    cat_state_t cat;
    logic [4:0] cnt;
    logic       cat_n;
    logic       hot_oe;
    logic       thermal_control_circuit;
    logic       trip_oe;
    logic       reg_fault;
    logic       halt;
    // Cycles the error output has been low, saturating; only the checks read it
    logic [4:0] low_run;
  } prot_state_t;

  prot_state_t st;
  prot_state_t next_st;
  logic        core_good;
  logic        sust_good;
  logic        ext_hot_n;
  logic        power_ok;
  logic        trip_now;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  pin_sync3 u_sync_core
  (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_core_supply_good),
    .o_level   (core_good)
  );
  pin_sync3 u_sync_sust
  (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_sustain_supply_good),
    .o_level   (sust_good)
  );
  // Our own drive also shows on the sampled pin; left unmasked, so it engages control too
  pin_sync3 u_sync_hot
  (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_over_temperature_n),
    .o_level   (ext_hot_n)
  );

  // Supplies are trusted from reset on, since the filter resets high, until it agrees on low
  assign power_ok = core_good && sust_good;
  assign trip_now = (i_junction_temp > err_therm_pkg::TRIP_TEMP_C) || i_regulator_fault_event;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.hot_oe = i_at_max_temp;
    next_st.thermal_control_circuit = i_tcc_enable && (i_at_max_temp || !ext_hot_n);
    // Trip is latched: once halted, only a power cycle or reset restarts
    if (trip_now)
    begin
      next_st.trip_oe = 1'b1;
      next_st.halt = 1'b1;
    end
    if (i_regulator_fault_event)
    begin
      next_st.reg_fault = 1'b1;
    end
    case (st.cat)
      CE_IDLE:
      begin
        if (i_internal_fault)
        begin
          next_st.cat = CE_HOLD;
        end
        else if (i_machine_check_fault)
        begin
          next_st.cat = CE_PULSE;
          next_st.cnt = err_therm_pkg::MCHK_CNT_LOAD;
        end
      end
      CE_PULSE:
      begin
        if (i_internal_fault)
        begin
          next_st.cat = CE_HOLD;
        end
        else if (st.cnt == 5'h01)
        begin
          next_st.cat = CE_IDLE;
        end
        next_st.cnt = st.cnt - 5'h01;
      end
      CE_HOLD:
      begin
        next_st.cat = CE_HOLD;
      end
      default:
      begin
        next_st.cat = CE_IDLE;
      end
    endcase
    next_st.cat_n = (next_st.cat == CE_IDLE);
    if (i_warm_reset)
    begin
      next_st.cat = CE_IDLE;
      next_st.cat_n = 1'b1;
      next_st.cnt = 5'h00;
    end
    if (!power_ok)
    begin
      next_st = '{cat: CE_IDLE, cnt: 5'h00, cat_n: 1'b1, hot_oe: 1'b0, thermal_control_circuit: 1'b0,
                  trip_oe: 1'b0, reg_fault: 1'b0, halt: 1'b0, low_run: 5'h00};
    end
    // Counted after every override, so it follows the output itself
    if (next_st.cat_n)
    begin
      next_st.low_run = 5'h00;
    end
    else if (st.low_run != 5'h1f)
    begin
      next_st.low_run = st.low_run + 5'h01;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st <= '{cat: CE_IDLE, cnt: 5'h00, cat_n: 1'b1, hot_oe: 1'b0, thermal_control_circuit: 1'b0,
              trip_oe: 1'b0, reg_fault: 1'b0, halt: 1'b0, low_run: 5'h00};
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_catastrophic_error_n    = st.cat_n;
  assign o_over_temperature_n      = err_therm_pkg::RST_PIN_LOW;
  assign o_over_temperature_oe     = st.hot_oe;
  assign o_thermal_shutdown_n      = err_therm_pkg::RST_PIN_LOW;
  assign o_thermal_shutdown_oe     = st.trip_oe;
  assign o_regulator_fault         = st.reg_fault;
  assign o_thermal_control_circuit = st.thermal_control_circuit;
  assign o_halt_execution          = st.halt;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_mchk_no_early: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (!o_catastrophic_error_n && st.low_run < err_therm_pkg::MCHK_CNT_LOAD && power_ok && !i_warm_reset)
    |=> !o_catastrophic_error_n)
    else $error("machine check pulse ended early");
  a_mchk_pulse_len: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (st.cat != CE_HOLD && st.low_run == err_therm_pkg::MCHK_CNT_LOAD && !i_internal_fault)
    |=> o_catastrophic_error_n)
    else $error("machine check pulse longer than 16 cycles");
  a_internal_fault_hold: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (st.cat == CE_HOLD && power_ok && !i_warm_reset) |=> !o_catastrophic_error_n)
    else $error("internal fault error released early");
  a_fault_asserts: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (power_ok && !i_warm_reset && (i_internal_fault || (i_machine_check_fault && st.cat == CE_IDLE)))
    |=> !o_catastrophic_error_n)
    else $error("catastrophic error not asserted");
  a_hot_drive: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (power_ok && i_at_max_temp) |=> o_over_temperature_oe)
    else $error("over-temperature not driven");
  a_ext_hot_tcc: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (power_ok && i_tcc_enable && !ext_hot_n) |=> o_thermal_control_circuit)
    else $error("external hot did not engage control");
  a_trip_halt: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (power_ok && i_junction_temp > err_therm_pkg::TRIP_TEMP_C) |=> (o_thermal_shutdown_oe && o_halt_execution))
    else $error("thermal trip missing");
  a_reg_fault_trip: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_regulator_fault |-> o_thermal_shutdown_oe)
    else $error("regulator fault without shutdown");
  a_power_gate: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !power_ok |=> (o_catastrophic_error_n && !o_thermal_shutdown_oe && !o_regulator_fault))
    else $error("outputs active without supply good");
endmodule // err_therm_protect

// ### bench/platform_model.sv
// Platform controller model: supply sequencing and over-temperature pull-down
`timescale 1ns/1ps
module platform_model
(
  // Clock
  input  wire logic i_mclk,
  // Bench control
  input  wire logic i_supply_on,
  input  wire logic i_ext_hot,
  // Device side
  input  wire logic i_over_temperature_oe,
  output logic      o_core_supply_good,
  output logic      o_sustain_supply_good,
  output logic      o_over_temperature_n
);
  logic [2:0] ramp;
  initial ramp = 3'h0;
  // Levels come from a register that counts up and clears to zero, so they cannot glitch
  always @(posedge i_mclk)
    ramp <= i_supply_on ? ((ramp == 3'h7) ? ramp : ramp + 3'h1) : 3'h0;
  assign o_sustain_supply_good = (ramp >= 3'h2);
  assign o_core_supply_good    = (ramp >= 3'h4);
  // Pulled up; either party may pull it low
  assign o_over_temperature_n  = ~(i_over_temperature_oe | i_ext_hot);
endmodule // platform_model

// ### bench/err_therm_protect_test.sv
// Self-checking bench for the error and thermal protection block
`timescale 1ns/1ps
module err_therm_protect_test;
  logic       mclk = 1'b0;
  logic       reset_n = 1'b0;
  logic       warm = 1'b0, mchk = 1'b0, ifault = 1'b0, rfault = 1'b0;
  logic       at_max = 1'b0, tcc_en = 1'b1, supply_on = 1'b1, ext_hot = 1'b0;
  logic [7:0] jtemp = 8'h19;
  logic       core_good, sus_good, ot_line, ot_n, ot_oe, cat_n, trip_n, trip_oe, reg_f, thermal_control_circuit, halt;
  int         error_cnt = 0;
  int         total_checks = 0;
  int         i;

  always #(err_therm_pkg::CLK_PERIOD_NS / 2) mclk = ~mclk;

  platform_model i_platform_model (.i_mclk(mclk), .i_supply_on(supply_on), .i_ext_hot(ext_hot),
    .i_over_temperature_oe(ot_oe), .o_core_supply_good(core_good), .o_sustain_supply_good(sus_good),
    .o_over_temperature_n(ot_line));

  err_therm_protect i_err_therm_protect (.i_mclk(mclk), .i_reset_n(reset_n), .i_warm_reset(warm),
    .i_core_supply_good(core_good), .i_sustain_supply_good(sus_good), .i_machine_check_fault(mchk),
    .i_internal_fault(ifault), .i_regulator_fault_event(rfault), .i_at_max_temp(at_max),
    .i_junction_temp(jtemp), .i_tcc_enable(tcc_en), .i_over_temperature_n(ot_line),
    .o_over_temperature_n(ot_n), .o_over_temperature_oe(ot_oe), .o_catastrophic_error_n(cat_n),
    .o_thermal_shutdown_n(trip_n), .o_thermal_shutdown_oe(trip_oe), .o_regulator_fault(reg_f),
    .o_thermal_control_circuit(thermal_control_circuit), .o_halt_execution(halt));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Drop both supplies, show that a machine check raises nothing and the latched outputs are clear, then bring them back
  task automatic supply_cycle();
    supply_on = 1'b0;
    cyc(8);
    mchk = 1'b1;
    cyc(1);
    mchk = 1'b0;
    check({cat_n, trip_oe, halt, reg_f}, 8'h08);
    supply_on = 1'b1;
    cyc(12);
    check({cat_n, trip_oe, halt, reg_f}, 8'h08);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    check({cat_n, trip_oe, ot_oe, reg_f, halt}, 8'h10);
    $display("t_reset done");
  endtask

  task automatic t_mcheck();
    mchk = 1'b1;
    for (i = 1; i <= 16; i++)
    begin
      cyc(1);
      mchk = (i == 8); // A retrigger mid-pulse must not stretch it
      check(cat_n, 1'b0);
    end
    cyc(1);
    check(cat_n, 1'b1);
    $display("t_mcheck done");
  endtask

  task automatic t_ifault();
    ifault = 1'b1;
    cyc(1);
    ifault = 1'b0;
    cyc(40);
    check(cat_n, 1'b0);
    warm = 1'b1;
    cyc(1);
    warm = 1'b0;
    check(cat_n, 1'b1);
    $display("t_ifault done");
  endtask

  task automatic t_overtemp();
    at_max = 1'b1;
    cyc(1);
    check({ot_oe, ot_n, ot_line}, 8'h04);
    cyc(5);
    check(thermal_control_circuit, 1'b1);
    tcc_en = 1'b0;
    cyc(6);
    check({ot_oe, thermal_control_circuit}, 8'h02);
    at_max = 1'b0;
    tcc_en = 1'b1;
    cyc(6);
    check({ot_oe, thermal_control_circuit}, 8'h00);
    ext_hot = 1'b1;
    cyc(6);
    check({ot_oe, thermal_control_circuit}, 8'h01);
    ext_hot = 1'b0;
    cyc(6);
    check(thermal_control_circuit, 1'b0);
    $display("t_overtemp done");
  endtask

  task automatic t_trip();
    jtemp = 8'h82;
    cyc(2);
    check({trip_oe, halt}, 8'h00);
    jtemp = 8'h83;
    cyc(1);
    jtemp = 8'h19;
    check({trip_oe, halt, trip_n}, 8'h06);
    cyc(4);
    check({trip_oe, halt}, 8'h03);
    supply_cycle();
    $display("t_trip done");
  endtask

  task automatic t_regfault();
    rfault = 1'b1;
    cyc(1);
    rfault = 1'b0;
    check({reg_f, trip_oe, halt}, 8'h07);
    supply_cycle();
    $display("t_regfault done");
  endtask

  initial
  begin
    cyc(4);
    reset_n = 1'b1;
    cyc(6);
    t_reset();
    t_mcheck();
    t_ifault();
    t_overtemp();
    t_trip();
    t_regfault();
    conclude();
  end

  // The tests take about 150 cycles; twenty times that means a hang
  initial
  begin
    #(err_therm_pkg::CLK_PERIOD_NS * 3000);
    error_cnt++;
    conclude();
  end
endmodule // err_therm_protect_test
